// ===== hdl/board_ctl_pkg.sv
// Constants for the board-control I/O port bank.
// Assumes a host that issues single-cycle I/O reads and writes on the system clock.
// Behaviour
// - Abort bit 4 flags switch-raised interrupt.
// - Abort bit 5: 0 clears/disables, 1 enables.
// - Abort bit 7 reads NVRAM wipe jumper.
// - LED bit 2 enables flash writes, page18.
// - LED bit 3 jumper or flash page18.
// - LED bit 5 enables upper BIOS window.
// - Watchdog bit 4 enables the timer.
// - Watchdog bit 5 selects reset on timeout.
// - Timeout gives interrupt or reset by select.
// - Watchdog bit 6 reports timeout status.
// - Writing watchdog bit 7 restarts, clears status.
// - Timeout after 1.6 seconds without kick.
// - Window bits 0-2 drive page bits 15-17.
// - Window bit 3 selects solid-state disk.
// - Window bits 5:4 select decoded range.
// - Window bit 6 bypasses slave swapping.
// - Window bit 7 bypasses master swapping.
// - No swap hardware: swap bits inert.
package board_ctl_pkg;
    localparam logic [9:0] ABORT_PORT_ADDR = 10'h218;
    localparam logic [9:0] LED_PORT_ADDR = 10'h219;
    localparam logic [9:0] WDOG_PORT_ADDR = 10'h233;
    localparam logic [9:0] WINDOW_PORT_ADDR = 10'h234;
    localparam int ABORT_FLAG_BIT = 4;
    localparam int ABORT_EN_BIT = 5;
    localparam int SPARE1_BIT = 6;
    localparam int WIPE_BIT = 7;
    localparam int FAULT_BIT = 0;
    localparam int PASS_BIT = 1;
    localparam int FLASH_WE_BIT = 2;
    localparam int PAGE18_BIT = 3;
    localparam int BIOS_WIN_BIT = 5;
    localparam int WD_EN_BIT = 4;
    localparam int WD_RST_SEL_BIT = 5;
    localparam int WD_FLAG_BIT = 6;
    localparam int WD_KICK_BIT = 7;
    localparam int SSD_BIT = 3;
    localparam int RANGE_LO_BIT = 4;
    localparam int SLAVE_SWAP_BIT = 6;
    localparam int MASTER_SWAP_BIT = 7;
    localparam logic [7:0] LED_RESET = 8'h00;
    localparam logic [7:0] WINDOW_RESET = 8'h00;
    localparam logic [7:0] WDOG_RESET = 8'h00;
    localparam logic [7:0] ABORT_WMASK = 8'h20;
    localparam logic [7:0] LED_WMASK = 8'h2f;
    localparam logic [7:0] WDOG_WMASK = 8'h30;
    localparam logic [7:0] WINDOW_WMASK = 8'hff;
    localparam logic [7:0] SWAP_MASK = 8'hc0;
    localparam real CLOCK_MHZ = 200.0;
    localparam real WD_TIMEOUT_S = 1.6;
    localparam longint WD_TIMEOUT_CYCLES = longint'(WD_TIMEOUT_S * CLOCK_MHZ * 1.0e6);
    localparam int RESET_PULSE_CYCLES = 16;
endpackage

// ===== hdl/board_ctl_ports.sv
// Four 8-bit board-control I/O ports: abort, LED/BIOS, watchdog, memory window.
// Assumes single-cycle host I/O strobes on I_CLOCK; jumper and switch pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module board_ctl_ports
    import board_ctl_pkg::*;
#(
    parameter longint WD_TIMEOUT = WD_TIMEOUT_CYCLES,
    parameter bit HAS_SWAP_HW = 1'b1
) (
    input wire logic I_CLOCK,
    input wire logic I_RESETN,
    input wire logic [9:0] I_IO_ADDR,
    input wire logic I_IO_WR,
    input wire logic I_IO_RD,
    input wire logic [7:0] I_IO_WDATA,
    output logic [7:0] O_IO_RDATA,
    output logic O_IO_HIT,
    input wire logic I_ABORT_SWITCH,
    input wire logic I_SPARE_JUMPER_ONE,
    input wire logic I_SPARE_JUMPER_TWO,
    input wire logic I_NVRAM_WIPE_JUMPER,
    output logic O_ABORT_IRQ,
    output logic O_FAULT_LED_N,
    output logic O_PASS_LED,
    output logic O_FLASH_WRITE_ENABLE,
    output logic O_FLASH_PAGE_BIT18,
    output logic O_UPPER_BIOS_WINDOW_ENABLE,
    output logic O_WATCHDOG_IRQ,
    output logic O_MASTER_RESET,
    output logic [2:0] O_ROM_PAGE,
    output logic O_SOLID_STATE_DISK_SELECT,
    output logic [1:0] O_RANGE_SELECT,
    output logic O_SLAVE_SWAP_BYPASS,
    output logic O_MASTER_SWAP_BYPASS
);
    // Two-flop synchronisers for all pin inputs
    logic [3:0] pin_meta_reg;
    logic [3:0] pin_sync_reg;
    logic abort_prev_reg;
    logic abort_sw;
    logic spare_one;
    logic spare_two;
    logic nvram_wipe_jumper;

    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            pin_meta_reg <= 4'h0;
            pin_sync_reg <= 4'h0;
            abort_prev_reg <= 1'b0;
        end else begin
            pin_meta_reg <= {I_NVRAM_WIPE_JUMPER, I_SPARE_JUMPER_TWO, I_SPARE_JUMPER_ONE, I_ABORT_SWITCH};
            pin_sync_reg <= pin_meta_reg;
            abort_prev_reg <= pin_sync_reg[0];
        end
    end

    assign abort_sw = pin_sync_reg[0];
    assign spare_one = pin_sync_reg[1];
    assign spare_two = pin_sync_reg[2];
    assign nvram_wipe_jumper = pin_sync_reg[3];

    function automatic logic port_hit(input logic [9:0] addr, input logic [9:0] port);
        port_hit = (addr == port);
    endfunction

    logic wr_abort;
    logic wr_led;
    logic wr_wdog;
    logic wr_window;
    assign wr_abort = I_IO_WR && port_hit(I_IO_ADDR, ABORT_PORT_ADDR);
    assign wr_led = I_IO_WR && port_hit(I_IO_ADDR, LED_PORT_ADDR);
    assign wr_wdog = I_IO_WR && port_hit(I_IO_ADDR, WDOG_PORT_ADDR);
    assign wr_window = I_IO_WR && port_hit(I_IO_ADDR, WINDOW_PORT_ADDR);

    // Control state
    logic abort_irq_enable_reg;
    logic abort_irq_enable_next;
    logic abort_irq_flag_reg;
    logic abort_irq_flag_next;
    logic [7:0] led_reg;
    logic [7:0] led_next;
    logic [7:0] wdog_reg;
    logic [7:0] wdog_next;
    logic watchdog_expired_flag_reg;
    logic watchdog_expired_flag_next;
    logic [7:0] window_reg;
    logic [7:0] window_next;
    logic [4:0] rst_cnt_reg;
    logic [4:0] rst_cnt_next;
    logic watchdog_kick;
    logic wd_expire;
    logic watchdog_enable;
    logic timeout_reset_select;
    logic [7:0] swap_keep;

    assign watchdog_enable = wdog_reg[WD_EN_BIT];
    assign timeout_reset_select = wdog_reg[WD_RST_SEL_BIT];
    assign watchdog_kick = wr_wdog && I_IO_WDATA[WD_KICK_BIT];
    // Without swap hardware the swap bits never store
    assign swap_keep = HAS_SWAP_HW ? 8'hff : ~SWAP_MASK;

    always_comb begin
        abort_irq_enable_next = abort_irq_enable_reg;
        abort_irq_flag_next = abort_irq_flag_reg;
        led_next = led_reg;
        wdog_next = wdog_reg;
        watchdog_expired_flag_next = watchdog_expired_flag_reg;
        window_next = window_reg;
        rst_cnt_next = rst_cnt_reg;
        if (wr_abort) begin
            abort_irq_enable_next = I_IO_WDATA[ABORT_EN_BIT];
        end
        if (wr_abort && !I_IO_WDATA[ABORT_EN_BIT]) begin
            abort_irq_flag_next = 1'b0;
        end
        // Switch press wins over a clearing write in the same cycle
        if (abort_irq_enable_reg && abort_sw && !abort_prev_reg) begin
            abort_irq_flag_next = 1'b1;
        end
        if (wr_led) begin
            led_next = I_IO_WDATA & LED_WMASK;
        end
        if (wr_wdog) begin
            wdog_next = I_IO_WDATA & WDOG_WMASK;
        end
        if (watchdog_kick) begin
            watchdog_expired_flag_next = 1'b0;
        end
        if (wd_expire) begin
            watchdog_expired_flag_next = 1'b1;
        end
        if (wr_window) begin
            window_next = I_IO_WDATA & WINDOW_WMASK & swap_keep;
        end
        if (wd_expire && timeout_reset_select) begin
            rst_cnt_next = 5'(RESET_PULSE_CYCLES);
        end else if (rst_cnt_reg != 5'h0) begin
            rst_cnt_next = rst_cnt_reg - 5'h1;
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            abort_irq_enable_reg <= 1'b0;
            abort_irq_flag_reg <= 1'b0;
            led_reg <= LED_RESET;
            wdog_reg <= WDOG_RESET;
            watchdog_expired_flag_reg <= 1'b0;
            window_reg <= WINDOW_RESET;
            rst_cnt_reg <= 5'h0;
        end else begin
            abort_irq_enable_reg <= abort_irq_enable_next;
            abort_irq_flag_reg <= abort_irq_flag_next;
            led_reg <= led_next;
            wdog_reg <= wdog_next;
            watchdog_expired_flag_reg <= watchdog_expired_flag_next;
            window_reg <= window_next;
            rst_cnt_reg <= rst_cnt_next;
        end
    end

    wdog_counter #(
        .TIMEOUT(WD_TIMEOUT)
    ) u_wdog (
        .i_clock(I_CLOCK),
        .i_resetn(I_RESETN),
        .i_enable(watchdog_enable),
        .i_kick(watchdog_kick),
        .o_expire(wd_expire)
    );

    // Read mux
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic hit;

    assign hit = port_hit(I_IO_ADDR, ABORT_PORT_ADDR) || port_hit(I_IO_ADDR, LED_PORT_ADDR)
        || port_hit(I_IO_ADDR, WDOG_PORT_ADDR) || port_hit(I_IO_ADDR, WINDOW_PORT_ADDR);
    assign O_IO_HIT = hit && (I_IO_RD || I_IO_WR);

    always_comb begin
        rdata_next = rdata_reg;
        if (I_IO_RD) begin
            rdata_next = 8'h00;
            if (port_hit(I_IO_ADDR, ABORT_PORT_ADDR)) begin
                rdata_next[ABORT_FLAG_BIT] = abort_irq_flag_reg;
                rdata_next[ABORT_EN_BIT] = abort_irq_enable_reg;
                rdata_next[SPARE1_BIT] = spare_one;
                rdata_next[WIPE_BIT] = nvram_wipe_jumper;
            end else if (port_hit(I_IO_ADDR, LED_PORT_ADDR)) begin
                rdata_next = led_reg;
                if (!led_reg[FLASH_WE_BIT]) begin
                    rdata_next[PAGE18_BIT] = spare_two;
                end
            end else if (port_hit(I_IO_ADDR, WDOG_PORT_ADDR)) begin
                rdata_next = wdog_reg;
                rdata_next[WD_FLAG_BIT] = watchdog_expired_flag_reg;
            end else if (port_hit(I_IO_ADDR, WINDOW_PORT_ADDR)) begin
                rdata_next = window_reg;
            end
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign O_IO_RDATA = rdata_reg;
    assign O_ABORT_IRQ = abort_irq_flag_reg;
    assign O_FAULT_LED_N = led_reg[FAULT_BIT];
    assign O_PASS_LED = led_reg[PASS_BIT];
    assign O_FLASH_WRITE_ENABLE = led_reg[FLASH_WE_BIT];
    // Page 18 only under software control while flash writes are on; software pairs it with page 15-17
    assign O_FLASH_PAGE_BIT18 = led_reg[FLASH_WE_BIT] & led_reg[PAGE18_BIT];
    assign O_UPPER_BIOS_WINDOW_ENABLE = led_reg[BIOS_WIN_BIT];
    // Interrupt level held while status stays set and reset is not chosen
    assign O_WATCHDOG_IRQ = watchdog_expired_flag_reg & ~timeout_reset_select;
    assign O_MASTER_RESET = (rst_cnt_reg != 5'h0);
    assign O_ROM_PAGE = window_reg[2:0];
    assign O_SOLID_STATE_DISK_SELECT = window_reg[SSD_BIT];
    assign O_RANGE_SELECT = window_reg[RANGE_LO_BIT +: 2];
    assign O_SLAVE_SWAP_BYPASS = window_reg[SLAVE_SWAP_BIT];
    assign O_MASTER_SWAP_BYPASS = window_reg[MASTER_SWAP_BIT];

    a_abort_disable: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (wr_abort && !I_IO_WDATA[ABORT_EN_BIT]) |=> !abort_irq_enable_reg)
        else $error("abort enable not cleared by write");

    a_abort_flag_set: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (abort_irq_enable_reg && abort_sw && !abort_prev_reg) |=> O_ABORT_IRQ)
        else $error("abort press not flagged");

    a_abort_gated: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (!abort_irq_enable_reg && !O_ABORT_IRQ && !wr_abort) |=> !O_ABORT_IRQ)
        else $error("abort flag set while disabled");

    a_led_reserved: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        I_IO_RD && port_hit(I_IO_ADDR, LED_PORT_ADDR) |=> (O_IO_RDATA[7:6] == 2'b00 && !O_IO_RDATA[4]))
        else $error("LED port reserved bits read nonzero");

    a_page18_gate: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        !O_FLASH_WRITE_ENABLE |-> !O_FLASH_PAGE_BIT18)
        else $error("page 18 driven while flash writes off");

    a_wd_disabled: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        !watchdog_enable |=> !wd_expire)
        else $error("watchdog expired while disabled");

    a_wd_kick_clear: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (watchdog_kick && !wd_expire) |=> !watchdog_expired_flag_reg)
        else $error("kick did not clear status");

    sequence s_expire_reset;
        wd_expire && timeout_reset_select;
    endsequence
    a_wd_reset: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        s_expire_reset |=> O_MASTER_RESET [*8])
        else $error("master reset not held after timeout");

    a_wd_irq: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (wd_expire && !timeout_reset_select && !wr_wdog) |=> O_WATCHDOG_IRQ)
        else $error("timeout interrupt missing");

    a_swap_inert: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        !HAS_SWAP_HW |-> (!O_SLAVE_SWAP_BYPASS && !O_MASTER_SWAP_BYPASS))
        else $error("swap bits active without swap hardware");

    a_fault_led: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        wr_led |=> (O_FAULT_LED_N == $past(I_IO_WDATA[FAULT_BIT])))
        else $error("fault LED does not follow write");

    a_pass_led: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        wr_led |=> (O_PASS_LED == $past(I_IO_WDATA[PASS_BIT])))
        else $error("pass LED does not follow write");

    a_flash_enable: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        wr_led |=> (O_FLASH_WRITE_ENABLE == $past(I_IO_WDATA[FLASH_WE_BIT])))
        else $error("flash write enable does not follow write");

    a_page18_drive: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (wr_led && I_IO_WDATA[FLASH_WE_BIT]) |=> (O_FLASH_PAGE_BIT18 == $past(I_IO_WDATA[PAGE18_BIT])))
        else $error("page 18 not driven from written bit");

    a_bios_window: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        wr_led |=> (O_UPPER_BIOS_WINDOW_ENABLE == $past(I_IO_WDATA[BIOS_WIN_BIT])))
        else $error("upper BIOS window does not follow write");

    a_wd_enable: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        wr_wdog |=> (watchdog_enable == $past(I_IO_WDATA[WD_EN_BIT])))
        else $error("watchdog enable does not follow write");

    a_wd_status: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        wd_expire |=> watchdog_expired_flag_reg)
        else $error("timeout status not set");

    a_rom_page: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        wr_window |=> (O_ROM_PAGE == $past(I_IO_WDATA[2:0])))
        else $error("ROM page bits do not follow write");

    a_disk_select: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        wr_window |=> (O_SOLID_STATE_DISK_SELECT == $past(I_IO_WDATA[SSD_BIT])))
        else $error("disk select does not follow write");

    a_range_select: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        wr_window |=> (O_RANGE_SELECT == $past(I_IO_WDATA[RANGE_LO_BIT +: 2])))
        else $error("range select does not follow write");

    a_slave_swap: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (HAS_SWAP_HW && wr_window) |=> (O_SLAVE_SWAP_BYPASS == $past(I_IO_WDATA[SLAVE_SWAP_BIT])))
        else $error("slave swap bypass does not follow write");

    a_master_swap: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (HAS_SWAP_HW && wr_window) |=> (O_MASTER_SWAP_BYPASS == $past(I_IO_WDATA[MASTER_SWAP_BIT])))
        else $error("master swap bypass does not follow write");

    sequence s_read_abort;
        I_IO_RD && port_hit(I_IO_ADDR, ABORT_PORT_ADDR);
    endsequence

    a_abort_read: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        s_read_abort |=> (O_IO_RDATA[ABORT_FLAG_BIT] == $past(abort_irq_flag_reg)))
        else $error("abort status read back wrong");

    a_abort_reserved: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        s_read_abort |=> (O_IO_RDATA[3:0] == 4'h0))
        else $error("abort port reserved bits read nonzero");

    sequence s_read_wdog;
        I_IO_RD && port_hit(I_IO_ADDR, WDOG_PORT_ADDR);
    endsequence

    a_wd_reserved: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        s_read_wdog |=> (O_IO_RDATA[3:0] == 4'h0 && !O_IO_RDATA[WD_KICK_BIT]))
        else $error("watchdog port reserved bits read nonzero");

    a_wd_status_read: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        s_read_wdog |=> (O_IO_RDATA[WD_FLAG_BIT] == $past(watchdog_expired_flag_reg)))
        else $error("timeout status read back wrong");

    a_led_write_hit: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        wr_led |-> O_IO_HIT)
        else $error("mapped write not acknowledged");

    a_window_write_hit: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        wr_window |-> O_IO_HIT)
        else $error("mapped write not acknowledged");
endmodule
`default_nettype wire

// ===== hdl/wdog_counter.sv
// Watchdog up-counter with expiry pulse.
// Assumes a single system clock; kick and enable come from the port bank on that clock.
`timescale 1ns/1ps
`default_nettype none
module wdog_counter #(
    parameter longint TIMEOUT = 64'd320000000
) (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_enable,
    input wire logic i_kick,
    output logic o_expire
);
    logic [31:0] count_reg;
    logic [31:0] count_next;
    logic expire_reg;
    logic expire_next;

    assign o_expire = expire_reg;

    always_comb begin
        count_next = count_reg;
        expire_next = 1'b0;
        if (!i_enable || i_kick) begin
            count_next = 32'h0;
        end else if (count_reg >= 32'(TIMEOUT - 1)) begin
            // Restart so an unkicked dog keeps signalling each period
            count_next = 32'h0;
            expire_next = 1'b1;
        end else begin
            count_next = count_reg + 32'h1;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            count_reg <= 32'h0;
            expire_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            expire_reg <= expire_next;
        end
    end
endmodule
`default_nettype wire

// ===== tb/board_control_io_ports_bench.sv
// Self-checking bench for the board-control port bank.
// Assumes io_host drives the I/O strobes; watchdog count shortened to WD cycles.
`timescale 1ns/1ps
`default_nettype none
module board_control_io_ports_bench;
    import board_ctl_pkg::*;
    localparam int WD = 50;
    logic clk, rstn, sw, j1, j2, jw, wr, rd, hit, uh, sswap2, mswap2;
    logic [9:0] addr;
    logic [7:0] wdata, rdata, rdata2, d, w, got;
    logic abort_irq, fault_n, pass, fwe, pg18, bios, wd_irq, mrst, ssd, sswap, mswap;
    logic [2:0] page;
    logic [1:0] range;
    int n_fail = 0, checked = 0, cycles = 0, n;
    logic [31:0] rng = 32'd57373;

    io_host host (.i_clock(clk), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata),
        .i_rdata(rdata), .i_hit(hit));
    board_ctl_ports #(.WD_TIMEOUT(WD), .HAS_SWAP_HW(1'b1)) DUT (.I_CLOCK(clk), .I_RESETN(rstn),
        .I_IO_ADDR(addr), .I_IO_WR(wr), .I_IO_RD(rd), .I_IO_WDATA(wdata), .O_IO_RDATA(rdata),
        .O_IO_HIT(hit), .I_ABORT_SWITCH(sw), .I_SPARE_JUMPER_ONE(j1), .I_SPARE_JUMPER_TWO(j2),
        .I_NVRAM_WIPE_JUMPER(jw), .O_ABORT_IRQ(abort_irq), .O_FAULT_LED_N(fault_n),
        .O_PASS_LED(pass), .O_FLASH_WRITE_ENABLE(fwe), .O_FLASH_PAGE_BIT18(pg18),
        .O_UPPER_BIOS_WINDOW_ENABLE(bios), .O_WATCHDOG_IRQ(wd_irq), .O_MASTER_RESET(mrst),
        .O_ROM_PAGE(page), .O_SOLID_STATE_DISK_SELECT(ssd), .O_RANGE_SELECT(range),
        .O_SLAVE_SWAP_BYPASS(sswap), .O_MASTER_SWAP_BYPASS(mswap));
    // Variant without swap hardware sees the same host traffic
    board_ctl_ports #(.WD_TIMEOUT(WD), .HAS_SWAP_HW(1'b0)) noswap (.I_CLOCK(clk), .I_RESETN(rstn),
        .I_IO_ADDR(addr), .I_IO_WR(wr), .I_IO_RD(rd), .I_IO_WDATA(wdata), .O_IO_RDATA(rdata2),
        .O_IO_HIT(), .I_ABORT_SWITCH(sw), .I_SPARE_JUMPER_ONE(j1), .I_SPARE_JUMPER_TWO(j2),
        .I_NVRAM_WIPE_JUMPER(jw), .O_ABORT_IRQ(), .O_FAULT_LED_N(), .O_PASS_LED(), .O_FLASH_WRITE_ENABLE(),
        .O_FLASH_PAGE_BIT18(), .O_UPPER_BIOS_WINDOW_ENABLE(), .O_WATCHDOG_IRQ(), .O_MASTER_RESET(),
        .O_ROM_PAGE(), .O_SOLID_STATE_DISK_SELECT(), .O_RANGE_SELECT(), .O_SLAVE_SWAP_BYPASS(sswap2),
        .O_MASTER_SWAP_BYPASS(mswap2));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [7:0] led_exp(input logic [7:0] v, input logic jmp);
        return {2'b00, v[5], 1'b0, v[2] ? v[3] : jmp, v[2:0]};
    endfunction

    function automatic logic [7:0] abort_exp(input logic flag, input logic en);
        return {jw, j1, en, flag, 4'h0};
    endfunction

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
        checked++;
        if (seen !== exp) begin
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
            n_fail++;
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask

    task automatic wr_chk(input logic [9:0] a, input logic [7:0] v);
        logic h;
        host.write_port(a, v, h);
        chk("write hit", 8'h01, {7'h0, h});
    endtask

    task automatic rd_chk(input string name, input logic [9:0] a, input logic [7:0] exp);
        logic h;
        host.read_port(a, got, h);
        chk(name, exp, got);
        chk("read hit", 8'h01, {7'h0, h});
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Ceiling well above the roughly 670 cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            end_sim();
        end
    end

    initial begin
        rstn = 1'b0;
        sw = 1'b0;
        {j1, j2, jw} = 3'b101;
        cyc(3);
        rstn = 1'b1;
        cyc(3);
        chk("reset outputs", 8'h00, {fault_n, pass, fwe, bios, wd_irq, mrst, abort_irq, ssd});
        chk("reset window", 8'h00, {mswap, sswap, range, ssd, page});
        rd_chk("reset led", LED_PORT_ADDR, led_exp(8'h00, j2));
        rd_chk("reset wdog", WDOG_PORT_ADDR, 8'h00);
        rd_chk("reset abort", ABORT_PORT_ADDR, abort_exp(1'b0, 1'b0));
        // Flash paging: page bit 18 and window page bits written together
        for (int i = 0; i < 24; i++) begin
            rng = xorshift(rng);
            d = (i == 0) ? 8'hff : (i == 1) ? 8'h08 : rng[7:0];
            w = (i == 0) ? 8'hff : rng[15:8];
            {j1, j2, jw} = rng[18:16];
            wr_chk(LED_PORT_ADDR, d);
            wr_chk(WINDOW_PORT_ADDR, w);
            chk("led outputs", {3'b000, d[5], d[3] & d[2], d[2:0]}, {3'b000, bios, pg18, fwe, pass, fault_n});
            chk("window outputs", w, {mswap, sswap, range, ssd, page});
            rd_chk("led read", LED_PORT_ADDR, led_exp(d, j2));
            rd_chk("window read", WINDOW_PORT_ADDR, w);
            chk("noswap read", {2'b00, w[5:0]}, rdata2);
            chk("noswap bits", 8'h00, {6'h0, mswap2, sswap2});
            rd_chk("abort read", ABORT_PORT_ADDR, abort_exp(1'b0, 1'b0));
            host.write_port(10'h21a, rng[23:16], uh);
            chk("unmapped hit", 8'h00, {7'h0, uh});
            host.read_port(10'h21a, got, uh);
            chk("unmapped read", 8'h00, got);
            rd_chk("led kept", LED_PORT_ADDR, led_exp(d, j2));
        end
        wr_chk(ABORT_PORT_ADDR, 8'hff);
        rd_chk("abort enable", ABORT_PORT_ADDR, abort_exp(1'b0, 1'b1));
        sw = 1'b1;
        cyc(6);
        rd_chk("abort flag", ABORT_PORT_ADDR, abort_exp(1'b1, 1'b1));
        chk("abort irq", 8'h01, {7'h0, abort_irq});
        sw = 1'b0;
        wr_chk(ABORT_PORT_ADDR, 8'h00);
        rd_chk("abort clear", ABORT_PORT_ADDR, abort_exp(1'b0, 1'b0));
        chk("abort irq off", 8'h00, {7'h0, abort_irq});
        sw = 1'b1;
        cyc(6);
        rd_chk("abort masked", ABORT_PORT_ADDR, abort_exp(1'b0, 1'b0));
        sw = 1'b0;
        wr_chk(WDOG_PORT_ADDR, 8'h90);
        cyc(WD - 10);
        rd_chk("wdog early", WDOG_PORT_ADDR, 8'h10);
        cyc(15);
        rd_chk("wdog expired", WDOG_PORT_ADDR, 8'h50);
        chk("wdog irq", 8'h01, {7'h0, wd_irq});
        chk("no master reset", 8'h00, {7'h0, mrst});
        // Kick carries the enable bit since every write rewrites it
        wr_chk(WDOG_PORT_ADDR, 8'h90);
        rd_chk("wdog kicked", WDOG_PORT_ADDR, 8'h10);
        chk("wdog irq gone", 8'h00, {7'h0, wd_irq});
        wr_chk(WDOG_PORT_ADDR, 8'h80);
        cyc(2 * WD + 10);
        rd_chk("wdog disabled", WDOG_PORT_ADDR, 8'h00);
        wr_chk(WDOG_PORT_ADDR, 8'hb0);
        n = 0;
        while (mrst !== 1'b1 && n < WD + 20) begin
            cyc(1);
            n++;
        end
        chk("reset delay ok", 8'h01, {7'h0, (n >= WD - 4 && n <= WD + 4)});
        chk("irq held off", 8'h00, {7'h0, wd_irq});
        rd_chk("wdog reset sts", WDOG_PORT_ADDR, 8'h70);
        wr_chk(WDOG_PORT_ADDR, 8'h80);
        rd_chk("wdog final", WDOG_PORT_ADDR, 8'h00);
        // Reset in mid-run while LEDs are set and the reset pulse is still out
        wr_chk(LED_PORT_ADDR, 8'h26);
        rstn = 1'b0;
        cyc(2);
        rstn = 1'b1;
        cyc(3);
        chk("mid reset outputs", 8'h00, {fault_n, pass, fwe, bios, wd_irq, mrst, abort_irq, ssd});
        chk("mid reset window", 8'h00, {mswap, sswap, range, ssd, page});
        rd_chk("mid reset led", LED_PORT_ADDR, led_exp(8'h00, j2));
        end_sim();
    end
endmodule
`default_nettype wire

// ===== tb/io_host.sv
// Host side of the port bank: issues single-cycle I/O writes and reads.
// Assumes the bench calls its tasks; strobes change only on falling edges.
`timescale 1ns/1ps
`default_nettype none
module io_host (
    input wire logic i_clock,
    output logic [9:0] o_addr,
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_wdata,
    input wire logic [7:0] i_rdata,
    input wire logic i_hit
);
    initial begin
        o_addr = 10'h000;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_wdata = 8'h00;
    end

    // Idle address and data are inverted so a stale value never looks valid
    task automatic write_port(input logic [9:0] a, input logic [7:0] d, output logic hit);
        @(negedge i_clock);
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        #1 hit = i_hit;
        @(negedge i_clock);
        o_wr = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask

    task automatic read_port(input logic [9:0] a, output logic [7:0] d, output logic hit);
        @(negedge i_clock);
        o_addr = a;
        o_rd = 1'b1;
        #1 hit = i_hit;
        @(negedge i_clock);
        o_rd = 1'b0;
        o_addr = ~a;
        d = i_rdata;
    endtask
endmodule
`default_nettype wire
